// [inc/icu_pkg.sv]
// Purpose: Shared constants and types of the interrupt control unit.
// Assumes: 8-bit register port, 13-bit program counter.
// Notes:   Register offsets are the byte addresses of the plain register port.

package icu_pkg;

   // ==================================================================
   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PC_W   = 13;
   localparam int CORE_W = 3;
   localparam int PER_W  = 8;

   // ==================================================================
   // Register offsets
   localparam logic [7:0] REG_STATUS    = 8'h03;
   localparam logic [7:0] REG_OPTION    = 8'h81;
   localparam logic [7:0] REG_CORE      = 8'h0B;
   localparam logic [7:0] REG_CORE_ALT  = 8'h8B;
   localparam logic [7:0] REG_PREQ      = 8'h0C;
   localparam logic [7:0] REG_PEN       = 8'h8C;
   localparam logic [7:0] REG_PWR       = 8'h8E;

   // ==================================================================
   // Field positions
   localparam int BIT_GLB      = 7;
   localparam int BIT_GRP      = 6;
   localparam int BIT_EN_LO    = 3;     // enables [5:3] pair with flags [2:0]
   localparam int BIT_EN_HI    = 5;
   localparam int BIT_TO       = 4;
   localparam int BIT_PD       = 3;
   localparam int BIT_EDGE_SEL = 6;
   localparam int BIT_POR      = 1;
   localparam int BIT_BOR      = 0;
   localparam int FLG_PINCHG   = 0;
   localparam int FLG_EXT      = 1;
   localparam int FLG_T0       = 2;

   // ==================================================================
   // Values
   localparam logic [7:0]      PER_IMPL_MASK = 8'hEF;   // bit 4 unimplemented
   localparam logic [2:0]      CORE_IMPL_MASK = 3'h7;
   localparam logic [PC_W-1:0] IRQ_VECTOR    = 13'h0004;
   localparam logic [PC_W-1:0] RESET_VECTOR  = 13'h0000;
   localparam logic [7:0]      T0_MAX        = 8'hFF;
   localparam logic [7:0]      T0_ZERO       = 8'h00;

   typedef enum logic [1:0] {ST_IDLE, ST_TAKE, ST_SLEEP, ST_WAKE} icu_st_e;
   typedef enum logic [1:0] {RK_MASTER, RK_WDT, RK_BOD} icu_rk_e;

   typedef struct packed {
      icu_st_e             st;
      logic                glb;
      logic                grp;
      logic [2:0]          core_en;
      logic [7:0]          per_en;
      logic                edge_sel;
      logic                to;
      logic                pd;
      logic                por_bit;
      logic                bor_bit;
      logic                pin_prev;
      logic [7:0]          t0_prev;
      logic                req_q;
      logic                pc_load;
      logic [PC_W-1:0]     pc_addr;
      logic [DATA_W-1:0]   rdata;
   } icu_core_s;

   // Power-on values: status 0001 1xxx, power control ---- --0x (x taken as 0)
   localparam icu_core_s CORE_RST = '{st: ST_IDLE, glb: 1'b0, grp: 1'b0, core_en: 3'h0,
      per_en: 8'h00, edge_sel: 1'b1, to: 1'b1, pd: 1'b1, por_bit: 1'b0, bor_bit: 1'b0,
      pin_prev: 1'b0, t0_prev: 8'h00, req_q: 1'b0, pc_load: 1'b1, pc_addr: 13'h0000,
      rdata: 8'h00};

endpackage : icu_pkg

// [inc/icu_flag_if.sv]
// Purpose: Carrier between the control logic and one bank of sticky flags.
// Assumes: One clock domain.
// Notes:   clr_all beats set_evt; set_evt beats a software write.

interface icu_flag_if #(parameter int W = 8);
   logic [W-1:0] set_evt;
   logic         wr_en;
   logic [W-1:0] wr_data;
   logic         clr_all;
   logic [W-1:0] flags;

   modport ctl  (output set_evt, output wr_en, output wr_data, output clr_all, input flags);
   modport bank (input set_evt, input wr_en, input wr_data, input clr_all, output flags);
endinterface : icu_flag_if

// [design/icu_flag_bank.sv]
// Purpose: Bank of sticky request flags, set by events, written by software.
// Assumes: Events are one-cycle pulses synchronous to clk.
// Notes:   Unimplemented bits stay zero.

module icu_flag_bank #(
   parameter int           W    = 8,
   parameter logic [W-1:0] IMPL = '1
) (
   input wire logic    clk,
   input wire logic    rst,
   icu_flag_if.bank    fb
);

   typedef struct packed {
      logic [W-1:0] flags;
   } icu_bank_s;

   icu_bank_s s_q;
   icu_bank_s s_d;

   // ==================================================================
   // Flag update
   always_comb begin
      s_d = s_q;
      if (fb.wr_en) begin
         s_d.flags = fb.wr_data & IMPL;
      end
      // An event in the same cycle as a clearing write still lands
      s_d.flags = s_d.flags | (fb.set_evt & IMPL); // RULE11
      if (fb.clr_all) begin
         s_d.flags = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign fb.flags = s_q.flags;

   // ==================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_set_wins;
      (|(fb.set_evt & IMPL)) && !fb.clr_all |=> ((fb.flags & $past(fb.set_evt & IMPL)) == $past(fb.set_evt & IMPL));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost in flag bank"); // RULE11

   property p_clr_all;
      fb.clr_all |=> fb.flags == '0;
   endproperty
   a_clr_all: assert property (p_clr_all) else $error("flags not cleared by reset"); // RULE3

endmodule : icu_flag_bank

// [design/icu_ctrl.sv]
// Purpose: Interrupt control unit: flags, enables, vectoring, sleep wake-up, reset kinds.
// Assumes: clk is the instruction clock; all inputs synchronous; rst is power-on reset.
// Notes:   Sequencer must obey pc_load and stack_push in the cycle they are high.
//
// How it works
// RULE1 - Eleven sources feed ten sticky flags
// RULE2 - Global enable gates every interrupt
// RULE3 - Every reset clears the global enable
// RULE4 - Return-from-interrupt sets global enable again
// RULE5 - Each source masked by its own enable
// RULE6 - Core flags live in core control register
// RULE7 - Peripheral flags and enables in separate registers
// RULE8 - Taking clears enable, pushes, loads 0004h
// RULE9 - Pin event to vector in three cycles
// RULE10 - Software clears serviced flags before re-enabling
// RULE11 - Flags set regardless of any enable
// RULE12 - Clearing global enable drops next-cycle take
// RULE13 - Wake runs next instruction, then maybe vectors
// RULE14 - Enabled request flags wake from sleep
// RULE15 - Interrupt wake sets time-out, clears power-down
// RULE16 - Hard resets load program counter with 000h
// RULE17 - Master clear in sleep gives 0001 0uuu
// RULE18 - Brown-out clears indication bit, others keep
// RULE19 - Selected pin edge sets external flag
// RULE20 - Timer0 wrap FFh to 00h sets flag
// RULE21 - Request needs global, own and group enables; here core flags need only global and own, group gates peripheral flags only
//
// Our own choices: the strobed register port and the address map.

module icu_ctrl (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [icu_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [icu_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [icu_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic                        ext_irq_pin,
   input  wire logic                        pin_change_evt,
   input  wire logic [7:0]                  timer0_count,
   input  wire logic [icu_pkg::PER_W-1:0]   periph_evt,
   input  wire logic                        return_from_irq_op,
   input  wire logic                        sleep_op,
   input  wire logic                        instr_done,
   input  wire logic                        sys_reset,
   input  wire icu_pkg::icu_rk_e            reset_kind,
   output logic                             pc_load,
   output logic      [icu_pkg::PC_W-1:0]    pc_load_addr,
   output logic                             stack_push,
   output logic                             irq_pending,
   output logic                             sleep_active,
   output logic                             wake
);

   icu_pkg::icu_core_s s_q;
   icu_pkg::icu_core_s s_d;

   icu_flag_if #(.W(icu_pkg::CORE_W)) core_fb ();
   icu_flag_if #(.W(icu_pkg::PER_W))  per_fb ();

   logic ext_edge;
   logic t0_ovf;
   logic core_hit;
   logic per_hit;
   logic irq_req;
   logic wr_core;
   logic glb_clr_wr;
   logic take;
   logic [icu_pkg::DATA_W-1:0] rd_val;

   // ==================================================================
   // Flag banks
   icu_flag_bank #(.W(icu_pkg::CORE_W), .IMPL(icu_pkg::CORE_IMPL_MASK)) u_core_flags ( // RULE6
      .clk (clk),
      .rst (rst),
      .fb  (core_fb)
   );

   icu_flag_bank #(.W(icu_pkg::PER_W), .IMPL(icu_pkg::PER_IMPL_MASK)) u_per_flags ( // RULE7
      .clk (clk),
      .rst (rst),
      .fb  (per_fb)
   );

   // ==================================================================
   // Event detection
   always_comb begin
      if (s_q.edge_sel) begin
         ext_edge = ext_irq_pin & ~s_q.pin_prev; // RULE19
      end else begin
         ext_edge = ~ext_irq_pin & s_q.pin_prev; // RULE19
      end
   end

   assign t0_ovf = (s_q.t0_prev == icu_pkg::T0_MAX) && (timer0_count == icu_pkg::T0_ZERO); // RULE20

   // Three core sources plus eight peripheral inputs; peripheral bit 4 has no flag
   assign core_fb.set_evt[icu_pkg::FLG_PINCHG] = pin_change_evt; // RULE1
   assign core_fb.set_evt[icu_pkg::FLG_EXT]    = ext_edge;
   assign core_fb.set_evt[icu_pkg::FLG_T0]     = t0_ovf;
   assign per_fb.set_evt  = periph_evt; // RULE1

   assign wr_core       = reg_wr && (reg_addr == icu_pkg::REG_CORE || reg_addr == icu_pkg::REG_CORE_ALT);
   assign core_fb.wr_en   = wr_core;
   assign core_fb.wr_data = reg_wdata[icu_pkg::CORE_W-1:0];
   assign core_fb.clr_all = sys_reset;
   assign per_fb.wr_en    = reg_wr && (reg_addr == icu_pkg::REG_PREQ);
   assign per_fb.wr_data  = reg_wdata;
   assign per_fb.clr_all  = sys_reset;

   // ==================================================================
   // Request and take
   assign core_hit = |(core_fb.flags & s_q.core_en); // RULE5
   assign per_hit  = |(per_fb.flags & s_q.per_en);   // RULE5
   assign irq_req  = s_q.glb && (core_hit || (s_q.grp && per_hit)); // RULE21 RULE2

   // A write that clears the global enable cancels the take already lined up
   assign glb_clr_wr = wr_core && !reg_wdata[icu_pkg::BIT_GLB];
   assign take = (s_q.st == icu_pkg::ST_IDLE) && s_q.req_q && irq_req && !glb_clr_wr && !sys_reset; // RULE12

   // ==================================================================
   // Read mux
   always_comb begin
      rd_val = 8'h00;
      unique case (reg_addr)
         icu_pkg::REG_CORE, icu_pkg::REG_CORE_ALT: begin
            rd_val = {s_q.glb, s_q.grp, s_q.core_en, core_fb.flags};
         end
         icu_pkg::REG_PREQ: begin
            rd_val = per_fb.flags;
         end
         icu_pkg::REG_PEN: begin
            rd_val = s_q.per_en;
         end
         icu_pkg::REG_STATUS: begin
            rd_val[icu_pkg::BIT_TO] = s_q.to;
            rd_val[icu_pkg::BIT_PD] = s_q.pd;
         end
         icu_pkg::REG_OPTION: begin
            rd_val[icu_pkg::BIT_EDGE_SEL] = s_q.edge_sel;
         end
         icu_pkg::REG_PWR: begin
            rd_val[icu_pkg::BIT_POR] = s_q.por_bit;
            rd_val[icu_pkg::BIT_BOR] = s_q.bor_bit;
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
   end

   // ==================================================================
   // Next state
   always_comb begin
      s_d          = s_q;
      s_d.pc_load  = 1'b0;
      s_d.rdata    = 8'h00;
      s_d.req_q    = irq_req; // RULE9
      s_d.pin_prev = ext_irq_pin;
      s_d.t0_prev  = timer0_count;
      if (reg_rd) begin
         s_d.rdata = rd_val;
      end
      if (wr_core) begin
         s_d.glb     = reg_wdata[icu_pkg::BIT_GLB];
         s_d.grp     = reg_wdata[icu_pkg::BIT_GRP];
         s_d.core_en = reg_wdata[icu_pkg::BIT_EN_HI:icu_pkg::BIT_EN_LO];
      end
      if (reg_wr && reg_addr == icu_pkg::REG_PEN) begin
         s_d.per_en = reg_wdata & icu_pkg::PER_IMPL_MASK;
      end
      if (reg_wr && reg_addr == icu_pkg::REG_OPTION) begin
         s_d.edge_sel = reg_wdata[icu_pkg::BIT_EDGE_SEL];
      end
      if (reg_wr && reg_addr == icu_pkg::REG_PWR) begin
         s_d.por_bit = reg_wdata[icu_pkg::BIT_POR];
         s_d.bor_bit = reg_wdata[icu_pkg::BIT_BOR];
      end
      if (return_from_irq_op) begin
         s_d.glb = 1'b1; // RULE4
      end
      unique case (s_q.st)
         icu_pkg::ST_IDLE: begin
            if (take) begin
               s_d.st      = icu_pkg::ST_TAKE;
               s_d.glb     = 1'b0;                 // RULE8
               s_d.pc_load = 1'b1;
               s_d.pc_addr = icu_pkg::IRQ_VECTOR;  // RULE8
            end else if (sleep_op) begin
               s_d.st = icu_pkg::ST_SLEEP;
               s_d.to = 1'b1;
               s_d.pd = 1'b0;
            end
         end
         icu_pkg::ST_TAKE: begin
            s_d.st = icu_pkg::ST_IDLE;
         end
         icu_pkg::ST_SLEEP: begin
            if (core_hit || per_hit) begin
               s_d.st = icu_pkg::ST_WAKE; // RULE14
               s_d.to = 1'b1;             // RULE15
               s_d.pd = 1'b0;             // RULE15
            end
         end
         icu_pkg::ST_WAKE: begin
            // Hold off the vector until the instruction after sleep has run
            if (instr_done) begin
               s_d.st = icu_pkg::ST_IDLE; // RULE13
            end
         end
      endcase
      if (sys_reset) begin
         s_d.st       = icu_pkg::ST_IDLE;
         s_d.glb      = 1'b0;                  // RULE3
         s_d.grp      = 1'b0;
         s_d.core_en  = 3'h0;
         s_d.per_en   = 8'h00;
         s_d.edge_sel = 1'b1;
         s_d.req_q    = 1'b0;
         s_d.pc_load  = 1'b1;                  // RULE16
         s_d.pc_addr  = icu_pkg::RESET_VECTOR; // RULE16
         unique case (reset_kind)
            icu_pkg::RK_MASTER: begin
               if (s_q.st == icu_pkg::ST_SLEEP) begin
                  s_d.to = 1'b1; // RULE17
                  s_d.pd = 1'b0; // RULE17
               end
            end
            icu_pkg::RK_WDT: begin
               s_d.to = 1'b0;
            end
            icu_pkg::RK_BOD: begin
               s_d.to      = 1'b1;
               s_d.pd      = 1'b1;
               s_d.por_bit = 1'b1;
               s_d.bor_bit = 1'b0; // RULE18
            end
            default: begin
               s_d.to = s_q.to;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= icu_pkg::CORE_RST; // RULE3 RULE16
      end else begin
         s_q <= s_d;
      end
   end

   // ==================================================================
   // Outputs
   assign reg_rdata    = s_q.rdata;
   assign pc_load      = s_q.pc_load;
   assign pc_load_addr = s_q.pc_addr;
   assign stack_push   = (s_q.st == icu_pkg::ST_TAKE); // RULE8
   assign irq_pending  = irq_req;
   assign sleep_active = (s_q.st == icu_pkg::ST_SLEEP);
   assign wake         = (s_q.st == icu_pkg::ST_SLEEP) && (core_hit || per_hit) && !sys_reset;

   // ==================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_no_take_without_glb;
      $rose(stack_push) |-> $past(s_q.glb) && !s_q.glb;
   endproperty
   a_no_take_without_glb: assert property (p_no_take_without_glb) else $error("taken with enable clear"); // RULE2

   property p_reset_glb;
      sys_reset |=> !s_q.glb && !stack_push;
   endproperty
   a_reset_glb: assert property (p_reset_glb) else $error("reset left global enable set"); // RULE3

   property p_ret_sets_glb;
      return_from_irq_op && !sys_reset && !take |=> s_q.glb;
   endproperty
   a_ret_sets_glb: assert property (p_ret_sets_glb) else $error("return did not set enable"); // RULE4

   property p_take;
      stack_push |-> pc_load && pc_load_addr == icu_pkg::IRQ_VECTOR && !s_q.glb;
   endproperty
   a_take: assert property (p_take) else $error("vector not loaded on take"); // RULE8

   sequence s_pin_quiet;
      (!reg_wr && !sys_reset && !sleep_op && !return_from_irq_op)[*2];
   endsequence

   property p_latency;
      (ext_edge && s_q.core_en[icu_pkg::FLG_EXT] && s_q.glb && !irq_req && !s_q.req_q
         && s_q.st == icu_pkg::ST_IDLE && !reg_wr && !sys_reset && !sleep_op) ##1 s_pin_quiet
         |=> stack_push;
   endproperty
   a_latency: assert property (p_latency) else $error("pin latency not three cycles"); // RULE9

   property p_flag_any_enable;
      ext_edge && !sys_reset |=> core_fb.flags[icu_pkg::FLG_EXT];
   endproperty
   a_flag_any_enable: assert property (p_flag_any_enable) else $error("pin flag not set"); // RULE11

   property p_glb_clear_blocks;
      glb_clr_wr && !return_from_irq_op |=> !stack_push [*2];
   endproperty
   a_glb_clear_blocks: assert property (p_glb_clear_blocks) else $error("take after enable cleared"); // RULE12

   property p_wake_first;
      s_q.st == icu_pkg::ST_WAKE |-> !stack_push ##1 !stack_push;
   endproperty
   a_wake_first: assert property (p_wake_first) else $error("vector before woken instruction"); // RULE13

   property p_wake_status;
      wake |=> s_q.to && !s_q.pd && s_q.st == icu_pkg::ST_WAKE;
   endproperty
   a_wake_status: assert property (p_wake_status) else $error("wake status pattern wrong"); // RULE15

   property p_reset_pc;
      sys_reset |=> pc_load && pc_load_addr == icu_pkg::RESET_VECTOR;
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("reset did not load 000h"); // RULE16

   property p_master_clear_sleep;
      sys_reset && reset_kind == icu_pkg::RK_MASTER && sleep_active |=> s_q.to && !s_q.pd;
   endproperty
   a_master_clear_sleep: assert property (p_master_clear_sleep) else $error("sleep master clear status wrong"); // RULE17

   property p_bor_keep;
      sys_reset && reset_kind != icu_pkg::RK_BOD |=> s_q.bor_bit == $past(s_q.bor_bit);
   endproperty
   a_bor_keep: assert property (p_bor_keep) else $error("indication bit changed"); // RULE18

   property p_t0;
      s_q.t0_prev == icu_pkg::T0_MAX && timer0_count == icu_pkg::T0_ZERO && !sys_reset
         |=> core_fb.flags[icu_pkg::FLG_T0];
   endproperty
   a_t0: assert property (p_t0) else $error("timer0 wrap missed"); // RULE20

   c_take:  cover property ($rose(stack_push));
   c_wake_vector: cover property (wake ##1 s_q.st == icu_pkg::ST_WAKE ##[1:20] stack_push);
   c_ignored: cover property (glb_clr_wr && s_q.req_q && irq_req);
   c_bod: cover property (sys_reset && reset_kind == icu_pkg::RK_BOD);

endmodule : icu_ctrl

// [verification/icu_seq_model.sv]
// Purpose: Sequencer stand-in: counts stack pushes, ends the wake instruction.
// Assumes: One clock; wake is a one-cycle pulse.
// Notes:   The instruction after wake ends two cycles later, the slow case.

module icu_seq_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       stack_push,
   input  wire logic       wake,
   output logic            instr_done,
   output logic      [3:0] push_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] dly_q;
   assign instr_done = dly_q[1];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dly_q    <= 2'h0;
         push_cnt <= 4'h0;
      end else begin
         dly_q    <= {dly_q[0], wake};
         push_cnt <= push_cnt + {3'h0, stack_push};
      end
   end
endmodule : icu_seq_model

// [verification/testbench.sv]
// Purpose: Self-checking bench of the interrupt control unit.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Software side clears serviced flags before re-enabling.

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst = 1, wr = 0, rd = 0, pin = 0, pc_evt = 0, ret = 0, slp = 0, srst = 0;
   logic [7:0]  addr = 8'h00, wd = 8'h00, t0 = 8'h00, pev = 8'h00;
   logic [7:0]  rdat;
   logic [12:0] ld_addr;
   logic        ld, push, pend, sact, wk, idone;
   logic [3:0]  pcnt;
   icu_pkg::icu_rk_e kind = icu_pkg::RK_MASTER;
   int error_cnt = 0, n_compared = 0, cyc = 0;

   icu_ctrl i_dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdat), .ext_irq_pin(pin), .pin_change_evt(pc_evt), .timer0_count(t0),
      .periph_evt(pev), .return_from_irq_op(ret), .sleep_op(slp), .instr_done(idone),
      .sys_reset(srst), .reset_kind(kind), .pc_load(ld), .pc_load_addr(ld_addr),
      .stack_push(push), .irq_pending(pend), .sleep_active(sact), .wake(wk));
   icu_seq_model i_seq (.clk(clk), .rst(rst), .stack_push(push), .wake(wk), .instr_done(idone),
      .push_cnt(pcnt));

   always #2.5 clk = ~clk;

   // ==================================================================
   // Helpers
   task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wd <= d; end
      @(posedge clk) wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input string nm, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(nm, {5'h0, exp}, {5'h0, rdat});
   endtask : rreg

   // Pulse one of the one-cycle inputs: 0 return, 1 pin change, 2 sleep
   // A selector, since a non-blocking write through a ref argument is not portable
   task automatic pulse(input int w);
      @(posedge clk) begin ret <= (w == 0); pc_evt <= (w == 1); slp <= (w == 2); end
      @(posedge clk) begin ret <= 1'b0; pc_evt <= 1'b0; slp <= 1'b0; end
   endtask : pulse

   // Waits for a PC load; returns cycles waited, 99 if none
   task automatic wload(input logic [12:0] va, input logic ps, input int mx, output int n);
      n = 99;
      for (int i = 1; i <= mx; i++) begin
         @(posedge clk) #1;
         if (ld === 1'b1) begin
            chk("pc_load_addr", va, ld_addr);
            chk("stack_push", {12'h0, ps}, {12'h0, push});
            n = i;
            break;
         end
      end
      if (n == 99) chk("pc_load seen", 13'h1, 13'h0);
   endtask : wload

   task automatic sreset(input icu_pkg::icu_rk_e k);
      int n;
      @(posedge clk) begin srst <= 1'b1; kind <= k; end
      @(posedge clk) srst <= 1'b0;
      #1 chk("reset pc_load", 13'h1, {12'h0, ld});
      chk("reset vector", icu_pkg::RESET_VECTOR, ld_addr);
   endtask : sreset

   // ==================================================================
   // Scenarios
   task automatic t_pin;
      int n;
      wreg(icu_pkg::REG_CORE, 8'h90);
      @(posedge clk) pin <= 1'b1;
      wload(icu_pkg::IRQ_VECTOR, 1'b1, 8, n);
      chk("rising latency ok", 13'h1, {12'h0, n >= 3 && n <= 4});
      rreg("core after take", icu_pkg::REG_CORE, 8'h12);
      wreg(icu_pkg::REG_CORE_ALT, 8'h10);
      pulse(0);
      rreg("core after return", icu_pkg::REG_CORE, 8'h90);
      wreg(icu_pkg::REG_OPTION, 8'h00);
      @(posedge clk) pin <= 1'b0;
      wload(icu_pkg::IRQ_VECTOR, 1'b1, 8, n);
      @(posedge clk) #1 chk("push count", 13'h2, {9'h0, pcnt});
      wreg(icu_pkg::REG_CORE, 8'h00);
      $display("test pin edges done");
   endtask : t_pin

   task automatic t_flags;
      int n;
      pulse(1);
      @(posedge clk) begin t0 <= 8'hFF; pev <= 8'hFF; end
      @(posedge clk) begin t0 <= 8'h00; pev <= 8'h00; end
      rreg("core flags", icu_pkg::REG_CORE, 8'h05);
      rreg("periph flags", icu_pkg::REG_PREQ, 8'hEF);
      wreg(icu_pkg::REG_PEN, 8'hEF);
      wreg(icu_pkg::REG_CORE, 8'h85);
      #1 chk("no group enable", 13'h0, {12'h0, pend});
      rreg("periph enables", icu_pkg::REG_PEN, 8'hEF);
      wreg(icu_pkg::REG_CORE, 8'hC5);
      #1 chk("group enabled", 13'h1, {12'h0, pend});
      wload(icu_pkg::IRQ_VECTOR, 1'b1, 6, n);
      wreg(icu_pkg::REG_PREQ, 8'h00);
      wreg(icu_pkg::REG_CORE, 8'h00);
      wreg(icu_pkg::REG_PEN, 8'h00);
      $display("test flags done");
   endtask : t_flags

   task automatic t_glb_drop;
      int n;
      pulse(1);
      // Enable held two cycles so a take is lined up when the clearing write lands
      @(posedge clk) begin wr <= 1'b1; addr <= icu_pkg::REG_CORE; wd <= 8'h89; end
      repeat (2) @(posedge clk);
      wd <= 8'h09;
      @(posedge clk) wr <= 1'b0;
      repeat (6) begin
         @(posedge clk) #1 chk("no take", 13'h0, {12'h0, ld});
      end
      rreg("still pending", icu_pkg::REG_CORE, 8'h09);
      wreg(icu_pkg::REG_CORE, 8'h89);
      wload(icu_pkg::IRQ_VECTOR, 1'b1, 6, n);
      wreg(icu_pkg::REG_CORE, 8'h00);
      $display("test enable drop done");
   endtask : t_glb_drop

   task automatic t_sleep;
      int n;
      wreg(icu_pkg::REG_CORE, 8'h88);
      pulse(2);
      #1 chk("sleep_active", 13'h1, {12'h0, sact});
      pulse(1);
      #1 n = 0;
      while (wk !== 1'b1 && n < 5) begin
         @(posedge clk) #1;
         n++;
      end
      chk("wake seen", 13'h1, {12'h0, wk});
      wload(icu_pkg::IRQ_VECTOR, 1'b1, 10, n);
      rreg("status after wake", icu_pkg::REG_STATUS, 8'h10);
      wreg(icu_pkg::REG_CORE, 8'h00);
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_resets;
      wreg(icu_pkg::REG_CORE, 8'hB8);
      sreset(icu_pkg::RK_BOD);
      rreg("power ctl after brown-out", icu_pkg::REG_PWR, 8'h02);
      rreg("status after brown-out", icu_pkg::REG_STATUS, 8'h18);
      rreg("core after brown-out", icu_pkg::REG_CORE, 8'h00);
      pulse(2);
      sreset(icu_pkg::RK_MASTER);
      rreg("status clear in sleep", icu_pkg::REG_STATUS, 8'h10);
      sreset(icu_pkg::RK_WDT);
      rreg("status after watchdog", icu_pkg::REG_STATUS, 8'h00);
      rreg("power ctl kept", icu_pkg::REG_PWR, 8'h02);
      $display("test resets done");
   endtask : t_resets

   // ==================================================================
   // Run control
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // A full run takes about 115 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         $display("Error timeout expected done seen running");
         print_verdict();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk("power-on pc_load", 13'h1, {12'h0, ld});
      rreg("power-on core", icu_pkg::REG_CORE, 8'h00);
      rreg("power-on status", icu_pkg::REG_STATUS, 8'h18);
      rreg("unmapped", 8'h55, 8'h00);
      t_pin();
      t_flags();
      t_glb_drop();
      t_sleep();
      t_resets();
      print_verdict();
   end
endmodule : testbench
